// ---- src/eby_device.sv ----
/*
  eby_device: processor end; edge detection on event pins, management
  mode entry, stop clock, bus request and bus yield.
  assumes: core drives the boundary, bus-cycle and restore strobes from
  sys_clk logic; link event pins are asynchronous and synchronised here, bus_yield_req is sampled directly.
*/
`timescale 1ns/1ps
`default_nettype none
module eby_device #(
  parameter int unsigned NMI_LOW = eby_pkg::NMI_LOW_CLKS,
  parameter int unsigned SRST_LEN = eby_pkg::SOFT_RESET_CLKS
) (
  input  wire logic                         sys_clk,
  input  wire logic                         reset,
  eby_if.device                             link,
  input  wire logic                         insn_boundary,
  input  wire logic                         string_iter,
  input  wire logic                         locked_seq,
  input  wire logic                         bus_cycle_active,
  input  wire logic                         core_bus_req,
  input  wire logic                         save_done,
  input  wire logic                         resume_from_mgmt,
  input  wire logic                         restore_done,
  input  wire logic                         drain_done,
  input  wire logic                         higher_irq,
  output logic                              nmi_taken,
  output logic                              mgmt_mode,
  output logic                              core_reset,
  output logic [eby_pkg::BASE_WIDTH-1:0]    mgmt_base_register,
  input  wire logic                         base_we,
  input  wire logic [eby_pkg::BASE_WIDTH-1:0] base_wdata
);
  import eby_pkg::*;

  logic [SYNC_STAGES-1:0] s_nmi, s_srst, s_smi, s_stp;
  logic                   nmi_d, smi_d;
  logic [CNT_WIDTH-1:0]   nmi_low_cnt, srst_cnt;
  logic                   smi_pend;
  logic                   soft_active;
  eby_core_state_t        core_st;
  eby_bus_state_t         bus_st;

  logic nmi_s, srst_s, smi_s, stp_s;
  assign nmi_s  = s_nmi[SYNC_STAGES-1];
  assign srst_s = s_srst[SYNC_STAGES-1];
  assign smi_s  = s_smi[SYNC_STAGES-1];
  assign stp_s  = s_stp[SYNC_STAGES-1];

  // sync chains idle at inactive levels; first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_nmi  <= '0;
      s_srst <= '0;
      s_smi  <= '1;
      s_stp  <= '1;
    end else begin
      s_nmi  <= {s_nmi[SYNC_STAGES-2:0], link.nmi};
      s_srst <= {s_srst[SYNC_STAGES-2:0], link.soft_reset_in};
      s_smi  <= {s_smi[SYNC_STAGES-2:0], link.mgmt_irq_n};
      s_stp  <= {s_stp[SYNC_STAGES-2:0], link.stop_clock_req_n};
    end
  end

  // soft reset only counts once held long enough; short glitches ignored
  always_ff @(posedge sys_clk) begin
    if (reset || !srst_s) begin
      srst_cnt <= '0;
    end else if (srst_cnt < CNT_WIDTH'(SRST_LEN)) begin
      srst_cnt <= srst_cnt + 1'b1;
    end
  end
  assign soft_active = srst_s && (srst_cnt >= CNT_WIDTH'(SRST_LEN - 1));

  always_ff @(posedge sys_clk) begin
    core_reset <= reset || soft_active;
  end

  logic rst_all;
  assign rst_all = reset || soft_active;

  // base survives soft reset, only hard reset reloads it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mgmt_base_register <= BASE_RESET_VALUE;
    end else if (base_we && !soft_active) begin
      mgmt_base_register <= base_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      nmi_d       <= 1'b0;
      nmi_low_cnt <= '0;
      nmi_taken   <= 1'b0;
    end else begin
      nmi_d     <= nmi_s;
      nmi_taken <= nmi_s && !nmi_d &&
                   (nmi_low_cnt >= CNT_WIDTH'(NMI_LOW));
      if (nmi_s) begin
        nmi_low_cnt <= '0;
      end else if (nmi_low_cnt < CNT_WIDTH'(NMI_LOW)) begin
        nmi_low_cnt <= nmi_low_cnt + 1'b1;
      end
    end
  end

  logic smi_fall, accept_pt, take_smi;
  assign smi_fall  = smi_d && !smi_s;
  assign accept_pt = (insn_boundary || string_iter) && !locked_seq;
  // one pending edge only; edges during handling merge into it and wait
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      smi_d    <= 1'b1;
      smi_pend <= 1'b0;
    end else begin
      smi_d <= smi_s;
      if (smi_fall) begin
        smi_pend <= 1'b1;
      end else if (take_smi) begin
        smi_pend <= 1'b0;
      end
    end
  end
  // nested edge waits: take only from run state, i.e. after restore
  assign take_smi = smi_pend && accept_pt && (core_st == EBY_RUN);

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      core_st <= EBY_RUN;
    end else begin
      case (core_st)
        EBY_RUN: begin
          if (take_smi) begin
            core_st <= EBY_MGMT_SAVE;
          end else if (!stp_s && insn_boundary && !higher_irq) begin
            core_st <= EBY_STOP_DRAIN;
          end
        end
        EBY_MGMT_SAVE:    if (save_done) core_st <= EBY_MGMT_RUN;
        EBY_MGMT_RUN:     if (resume_from_mgmt) core_st <= EBY_MGMT_RESTORE;
        EBY_MGMT_RESTORE: if (restore_done) core_st <= EBY_RUN;
        EBY_STOP_DRAIN:   if (drain_done) core_st <= EBY_STOP_GRANT;
        EBY_STOP_GRANT:   core_st <= EBY_STOPPED;
        EBY_STOPPED:      if (stp_s) core_st <= EBY_RUN;
        default:          core_st <= EBY_RUN;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      link.mgmt_active_n <= 1'b1;
      mgmt_mode          <= 1'b0;
    end else begin
      link.mgmt_active_n <= !(take_smi || (core_st == EBY_MGMT_SAVE) ||
                              (core_st == EBY_MGMT_RUN) ||
                              (core_st == EBY_MGMT_RESTORE &&
                               !restore_done));
      mgmt_mode <= (core_st == EBY_MGMT_RUN);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      link.stop_grant <= 1'b0;
    end else begin
      link.stop_grant <= (core_st == EBY_STOP_DRAIN) && drain_done;
    end
  end

  // bus request reflects the core even while yielded
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      link.internal_bus_req_out <= 1'b0;
    end else begin
      link.internal_bus_req_out <= core_bus_req;
    end
  end

  // yield request is a synchronous-timing pin, sampled directly
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      bus_st <= EBY_BUS_OWN;
    end else begin
      case (bus_st)
        EBY_BUS_OWN:
          if (link.bus_yield_req) bus_st <= EBY_BUS_FINISH;
        EBY_BUS_FINISH: begin
          if (!link.bus_yield_req) begin
            bus_st <= EBY_BUS_OWN;
          end else if (!bus_cycle_active && !locked_seq) begin
            bus_st <= EBY_BUS_YIELDED;
          end
        end
        EBY_BUS_YIELDED:
          if (!link.bus_yield_req) bus_st <= EBY_BUS_OWN;
        default: bus_st <= EBY_BUS_OWN;
      endcase
    end
  end

  logic go_yield;
  assign go_yield = (bus_st == EBY_BUS_FINISH) && link.bus_yield_req &&
                    !bus_cycle_active && !locked_seq;
  // ack and float come from one term so they always change together
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      link.bus_yield_ack <= 1'b0;
      link.bus_float     <= 1'b0;
    end else begin
      link.bus_yield_ack <= go_yield ||
        (bus_st == EBY_BUS_YIELDED && link.bus_yield_req);
      link.bus_float     <= go_yield ||
        (bus_st == EBY_BUS_YIELDED && link.bus_yield_req);
    end
  end
endmodule : eby_device
`default_nettype wire

// ---- src/eby_pkg.sv ----
/*
  eby_pkg: constants and types shared by both ends of the event and
  bus yield link.
  assumes: one clock, sys_clk at 250 MHz.
*/
package eby_pkg;
  localparam int unsigned CLK_PERIOD_PS    = 4000;
  localparam int unsigned NMI_LOW_CLKS     = 4;
  localparam int unsigned SOFT_RESET_CLKS  = 15;
  localparam int unsigned SYNC_STAGES      = 2;
  localparam int unsigned BASE_WIDTH       = 32;
  localparam logic [31:0] BASE_RESET_VALUE = 32'h0003_0000;
  localparam int unsigned CNT_WIDTH        = 5;

  typedef enum logic [2:0] {
    EBY_RUN,
    EBY_MGMT_SAVE,
    EBY_MGMT_RUN,
    EBY_MGMT_RESTORE,
    EBY_STOP_DRAIN,
    EBY_STOP_GRANT,
    EBY_STOPPED
  } eby_core_state_t;

  typedef enum logic [1:0] {
    EBY_BUS_OWN,
    EBY_BUS_FINISH,
    EBY_BUS_YIELDED
  } eby_bus_state_t;
endpackage : eby_pkg

// ---- src/eby_if.sv ----
/*
  eby_if: pins between the processor end and the system logic end.
  assumes: both ends clocked by the same sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface eby_if;
  logic nmi;
  logic soft_reset_in;
  logic mgmt_irq_n;
  logic mgmt_active_n;
  logic stop_clock_req_n;
  logic stop_grant;
  logic internal_bus_req_out;
  logic bus_yield_req;
  logic bus_yield_ack;
  logic bus_float;

  modport device (
    input  nmi, soft_reset_in, mgmt_irq_n, stop_clock_req_n, bus_yield_req,
    output mgmt_active_n, stop_grant, internal_bus_req_out, bus_yield_ack,
           bus_float
  );
  modport system (
    output nmi, soft_reset_in, mgmt_irq_n, stop_clock_req_n, bus_yield_req,
    input  mgmt_active_n, stop_grant, internal_bus_req_out, bus_yield_ack,
           bus_float
  );
endinterface : eby_if
`default_nettype wire

// ---- src/eby_system.sv ----
/*
  eby_system: system logic end; drives event pins and bus yield request
  from user commands with the required pulse shapes.
  assumes: same sys_clk as the device end.
*/
`timescale 1ns/1ps
`default_nettype none
module eby_system #(
  parameter int unsigned NMI_LOW = eby_pkg::NMI_LOW_CLKS,
  parameter int unsigned SRST_LEN = eby_pkg::SOFT_RESET_CLKS
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  eby_if.system     link,
  input  wire logic nmi_cmd,
  input  wire logic soft_reset_cmd,
  input  wire logic mgmt_irq_cmd,
  input  wire logic stop_cmd,
  input  wire logic stop_release,
  input  wire logic yield_cmd,
  output logic      busy,
  output logic      stop_granted,
  output logic      yield_granted,
  output logic      in_mgmt
);
  import eby_pkg::*;

  logic [CNT_WIDTH-1:0] nmi_cnt, srst_cnt;
  logic                 grant_seen;

  // nmi held low a full spacing before each rising edge
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      link.nmi <= 1'b0;
      nmi_cnt  <= '0;
    end else if (link.nmi) begin
      link.nmi <= 1'b0;
      nmi_cnt  <= '0;
    end else if (nmi_cnt < CNT_WIDTH'(NMI_LOW + SYNC_STAGES)) begin
      nmi_cnt <= nmi_cnt + 1'b1;
    end else if (nmi_cmd) begin
      link.nmi <= 1'b1;
    end
  end

  // extra margin covers the device synchroniser delay
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      link.soft_reset_in <= 1'b0;
      srst_cnt           <= '0;
    end else if (srst_cnt != '0) begin
      srst_cnt <= srst_cnt - 1'b1;
      link.soft_reset_in <= (srst_cnt != CNT_WIDTH'(1));
    end else if (soft_reset_cmd) begin
      srst_cnt           <= CNT_WIDTH'(SRST_LEN + SYNC_STAGES + 1);
      link.soft_reset_in <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      link.mgmt_irq_n <= 1'b1;
    end else begin
      link.mgmt_irq_n <= !(mgmt_irq_cmd && link.mgmt_irq_n);
    end
  end

  // release only honoured after the grant cycle was seen
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      link.stop_clock_req_n <= 1'b1;
      grant_seen            <= 1'b0;
    end else begin
      if (link.stop_clock_req_n) begin
        grant_seen <= 1'b0;
        if (stop_cmd) link.stop_clock_req_n <= 1'b0;
      end else begin
        if (link.stop_grant) grant_seen <= 1'b1;
        if (stop_release && grant_seen) begin
          link.stop_clock_req_n <= 1'b1;
        end
      end
    end
  end

  // yield request is always driven, never left open
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      link.bus_yield_req <= 1'b0;
    end else begin
      link.bus_yield_req <= yield_cmd;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy          <= 1'b0;
      stop_granted  <= 1'b0;
      yield_granted <= 1'b0;
      in_mgmt       <= 1'b0;
    end else begin
      busy          <= link.nmi || (srst_cnt != '0);
      stop_granted  <= grant_seen;
      yield_granted <= link.bus_yield_ack;
      in_mgmt       <= !link.mgmt_active_n;
    end
  end
endmodule : eby_system
`default_nettype wire

// ---- dv/eby_asserts.sv ----
/*
  eby_asserts: concurrent checks on the link between the two ends.
  assumes: instantiated in tb beside the eby_if instance, same sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module eby_asserts (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic nmi,
  input wire logic soft_reset_in,
  input wire logic mgmt_active_n,
  input wire logic stop_clock_req_n,
  input wire logic stop_grant,
  input wire logic bus_yield_req,
  input wire logic bus_yield_ack,
  input wire logic bus_float
);
  logic [4:0] srst_len;

  // saturates so a long hold never wraps below the minimum
  always_ff @(posedge sys_clk) begin
    srst_len <= (reset || !soft_reset_in) ? 5'h00
              : srst_len + {4'h0, srst_len != 5'h1f};
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_FLOAT_ACK: assert property (bus_float == bus_yield_ack)
    else $error("bus float differs from yield ack");
  AST_YIELD_ENTRY: assert property ($rose(bus_yield_ack)
    |-> $past(bus_yield_req, 2) && $past(bus_yield_req))
    else $error("yield ack without a held request");
  AST_YIELD_STAY: assert property (bus_yield_ack && bus_yield_req
    |=> bus_yield_ack)
    else $error("yield left while request high");
  AST_YIELD_LEAVE: assert property (!bus_yield_req |=> !bus_yield_ack)
    else $error("yield ack kept after request dropped");
  AST_STOP_HELD: assert property (stop_grant
    |-> !stop_clock_req_n && !$past(stop_clock_req_n))
    else $error("stop request released before grant");
  AST_STOP_PULSE: assert property (stop_grant
    |-> mgmt_active_n ##1 !stop_grant)
    else $error("stop grant not a single idle pulse");
  // soft reset legally drops management state, so it is excluded here
  AST_MGMT_ACTIVE: assert property (disable iff (reset || soft_reset_in)
    $fell(mgmt_active_n) |-> !mgmt_active_n [*3])
    else $error("mgmt active released too early");
  AST_NMI_LOW: assert property ($rose(nmi)
    |-> !$past(nmi, 2) && !$past(nmi, 3) && !$past(nmi, 4))
    else $error("nmi low time too short");
  AST_SRST_LEN: assert property ($fell(soft_reset_in)
    |-> srst_len >= 5'h0f)
    else $error("soft reset held too briefly");

  cover property ($rose(bus_yield_ack));
  cover property ($fell(mgmt_active_n));
  cover property (stop_grant);
  cover property ($fell(soft_reset_in));
endmodule : eby_asserts
`default_nettype wire

// ---- dv/tb.sv ----
/*
  tb: joins both ends through eby_if and checks the link behaviour.
  assumes: eby_pkg, eby_if, eby_device, eby_system, eby_asserts.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import eby_pkg::*;
  logic                  sys_clk, reset, insn_boundary, locked_seq;
  logic                  bus_cycle_active, core_bus_req, save_done;
  logic                  resume_from_mgmt, restore_done, drain_done;
  logic                  higher_irq, base_we, yield_cmd, busy, string_iter;
  logic                  nmi_taken, mgmt_mode, core_reset;
  logic                  stop_granted, yield_granted, in_mgmt;
  logic [BASE_WIDTH-1:0] base_wdata, mgmt_base_register;
  logic [4:0]            cmd;
  int                    bad_count, n_checks;

  eby_if link ();
  eby_device i_eby_device (.sys_clk(sys_clk), .reset(reset),
    .link(link.device), .insn_boundary(insn_boundary),
    .string_iter(string_iter), .locked_seq(locked_seq),
    .bus_cycle_active(bus_cycle_active),
    .core_bus_req(core_bus_req), .save_done(save_done),
    .resume_from_mgmt(resume_from_mgmt), .restore_done(restore_done),
    .drain_done(drain_done), .higher_irq(higher_irq),
    .nmi_taken(nmi_taken), .mgmt_mode(mgmt_mode), .core_reset(core_reset),
    .mgmt_base_register(mgmt_base_register), .base_we(base_we),
    .base_wdata(base_wdata));
  eby_system i_eby_system (.sys_clk(sys_clk), .reset(reset),
    .link(link.system), .nmi_cmd(cmd[0]), .soft_reset_cmd(cmd[1]),
    .mgmt_irq_cmd(cmd[2]), .stop_cmd(cmd[3]), .stop_release(cmd[4]),
    .yield_cmd(yield_cmd), .busy(busy), .stop_granted(stop_granted),
    .yield_granted(yield_granted), .in_mgmt(in_mgmt));
  eby_asserts i_eby_asserts (.sys_clk(sys_clk), .reset(reset),
    .nmi(link.nmi), .soft_reset_in(link.soft_reset_in),
    .mgmt_active_n(link.mgmt_active_n),
    .stop_clock_req_n(link.stop_clock_req_n), .stop_grant(link.stop_grant),
    .bus_yield_req(link.bus_yield_req), .bus_yield_ack(link.bus_yield_ack),
    .bus_float(link.bus_float));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  function automatic logic sig(input int k);
    case (k)
      0: return link.bus_yield_ack;
      1: return link.mgmt_active_n;
      2: return link.stop_grant;
      3: return nmi_taken;
      4: return core_reset;
      5: return mgmt_mode;
      default: return busy;
    endcase
  endfunction : sig

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // polls at the falling edge, clear of the driving edge
  task automatic wait_for(input int k, input logic v, input int n,
                          input string what);
    int i;
    @(negedge sys_clk);
    for (i = 0; i < n && sig(k) !== v; i++)
      @(negedge sys_clk);
    chk(what, {31'h0, v}, {31'h0, sig(k)});
  endtask : wait_for

  task automatic hold(input int k, input logic v, input int n,
                      input string what);
    int i;
    @(negedge sys_clk);
    for (i = 0; i < n && sig(k) === v; i++)
      @(negedge sys_clk);
    chk(what, {31'h0, v}, {31'h0, sig(k)});
  endtask : hold

  // only the shaped pulses make the system end busy
  task automatic pulse(input int b);
    if (b < 2) wait_for(6, 1'b0, 100, "system idle");
    @(posedge sys_clk);
    cmd[b] <= 1'b1;
    @(posedge sys_clk);
    cmd[b] <= 1'b0;
  endtask : pulse

  task automatic mgmt_cycle;
    @(posedge sys_clk);
    save_done <= 1'b1;
    @(posedge sys_clk);
    save_done <= 1'b0;
    wait_for(5, 1'b1, 4, "mgmt mode");
    chk("active in run", 32'h0, {31'h0, link.mgmt_active_n});
    chk("system sees mgmt", 32'h1, {31'h0, in_mgmt});
    @(posedge sys_clk);
    resume_from_mgmt <= 1'b1;
    @(posedge sys_clk);
    resume_from_mgmt <= 1'b0;
    restore_done <= 1'b1;
    @(posedge sys_clk);
    restore_done <= 1'b0;
    wait_for(1, 1'b1, 4, "mgmt exit");
  endtask : mgmt_cycle

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #20000;
    bad_count++;
    $display("[FAIL] watchdog expected end seen hang");
    finish_test();
  end

  initial begin
    {reset, insn_boundary, locked_seq, bus_cycle_active} = 4'hf;
    {core_bus_req, save_done, resume_from_mgmt, restore_done} = 4'h0;
    {drain_done, higher_irq, base_we, yield_cmd} = 4'h0;
    {insn_boundary, locked_seq, bus_cycle_active, string_iter} = 4'h0;
    cmd = 5'h00;
    base_wdata = 32'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk("base reset", BASE_RESET_VALUE, mgmt_base_register);
    @(posedge sys_clk);
    {core_bus_req, bus_cycle_active, locked_seq, yield_cmd} <= 4'hf;
    hold(0, 1'b0, 8, "ack in bus cycle");
    chk("bus req", 32'h1, {31'h0, link.internal_bus_req_out});
    @(posedge sys_clk);
    bus_cycle_active <= 1'b0;
    hold(0, 1'b0, 4, "ack in lock");
    @(posedge sys_clk);
    locked_seq <= 1'b0;
    wait_for(0, 1'b1, 6, "yield ack");
    chk("float", 32'h1, {31'h0, link.bus_float});
    hold(0, 1'b1, 10, "ack held");
    chk("bus req yielded", 32'h1, {31'h0, link.internal_bus_req_out});
    chk("yield seen", 32'h1, {31'h0, yield_granted});
    @(posedge sys_clk);
    {yield_cmd, core_bus_req} <= 2'h0;
    wait_for(0, 1'b0, 6, "ack release");
    chk("bus req off", 32'h0, {31'h0, link.internal_bus_req_out});
    $display("test yield done");
    pulse(0);
    wait_for(3, 1'b1, 20, "nmi taken");
    hold(3, 1'b0, 20, "nmi once");
    $display("test nmi done");
    pulse(2);
    hold(1, 1'b1, 10, "entry off boundary");
    // entry through a string iteration, not a boundary
    @(posedge sys_clk);
    {locked_seq, string_iter} <= 2'h3;
    hold(1, 1'b1, 6, "entry in lock");
    @(posedge sys_clk);
    locked_seq <= 1'b0;
    wait_for(1, 1'b0, 4, "mgmt entry");
    @(posedge sys_clk);
    {string_iter, insn_boundary} <= 2'h1;
    pulse(2);
    pulse(2);
    hold(1, 1'b0, 4, "active in save");
    mgmt_cycle();
    wait_for(1, 1'b0, 8, "pending entry");
    mgmt_cycle();
    hold(1, 1'b1, 12, "one pending only");
    $display("test mgmt done");
    @(posedge sys_clk);
    {higher_irq, drain_done} <= 2'h3;
    pulse(3);
    hold(2, 1'b0, 12, "grant under irq");
    @(posedge sys_clk);
    higher_irq <= 1'b0;
    wait_for(2, 1'b1, 12, "stop grant");
    chk("stop held", 32'h0, {31'h0, link.stop_clock_req_n});
    pulse(4);
    @(negedge sys_clk);
    chk("stop granted", 32'h1, {31'h0, stop_granted});
    repeat (3) @(negedge sys_clk);
    chk("stop free", 32'h1, {31'h0, link.stop_clock_req_n});
    $display("test stop done");
    @(posedge sys_clk);
    {base_we, base_wdata} <= {1'b1, 32'h1234_5678};
    @(posedge sys_clk);
    base_we <= 1'b0;
    pulse(1);
    wait_for(4, 1'b1, 40, "soft reset");
    chk("base kept", 32'h1234_5678, mgmt_base_register);
    wait_for(4, 1'b0, 40, "soft reset end");
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk("base hard", BASE_RESET_VALUE, mgmt_base_register);
    $display("test reset done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
